// >>> rtl/eoc_pkg.sv
// constants and mode codes for the external oscillator control register
`default_nettype none
package eoc_pkg;
  localparam logic [7:0] EOC_CTRL_ADDR = 8'h00_B1;
  localparam logic [7:0] EOC_CTRL_RESET = 8'h00_00;
  localparam int EOC_VALID_BIT = 7;
  localparam int EOC_MODE_MSB = 6;
  localparam int EOC_MODE_LSB = 4;
  localparam int EOC_RSVD_BIT = 3;
  localparam int EOC_BIAS_MSB = 2;
  localparam int EOC_BIAS_LSB = 0;
  // settle count of one: the flag stays masked for two cycles after a mode change
  localparam logic [1:0] EOC_SETTLE_CYC = 2'h1;

  typedef enum logic [2:0] {
    EOC_OFF0 = 3'h0,
    EOC_OFF1 = 3'h1,
    EOC_CMOS = 3'h2,
    EOC_CMOS_DIV2 = 3'h3,
    EOC_RC = 3'h4,
    EOC_CAP = 3'h5,
    EOC_XTAL = 3'h6,
    EOC_XTAL_DIV2 = 3'h7
  } eoc_mode_t;
endpackage
`default_nettype wire

// >>> rtl/eoc_ctrl.sv
// external oscillator control register with mode decode and status flag
`default_nettype none
module eoc_ctrl
  import eoc_pkg::*;
(
  input wire logic core_clk, // system clock, 40 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic [7:0] sfr_addr, // special-function register address
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  input wire logic [7:0] sfr_wdata, // write data
  output logic [7:0] sfr_rdata, // read data, registered, zero when not selected
  input wire logic osc_running, // analog side reports oscillator stable
  output logic osc_enable, // oscillator circuit powered
  output logic cmos_sel, // CMOS clock input path
  output logic rc_sel, // RC oscillator configuration
  output logic cap_sel, // capacitor oscillator configuration
  output logic xtal_sel, // crystal oscillator configuration
  output logic div2_sel, // divide-by-two stage in path
  output logic [2:0] ext_osc_bias_level // bias current setting
);

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] ext_osc_mode_field_r, ext_osc_mode_field_nxt;
  logic [2:0] bias_r, bias_nxt;
  logic [1:0] settle_r, settle_nxt;
  logic ext_osc_valid_flag_r, valid_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic en_r, en_nxt, cmos_r, cmos_nxt, rc_r, rc_nxt, cap_r, cap_nxt;
  logic xtal_r, xtal_nxt, div2_r, div2_nxt;
  logic wr_hit, rd_hit;
  logic [7:0] reg_view;
  eoc_mode_t mode_new;

  assign wr_hit = sfr_wr && (sfr_addr == EOC_CTRL_ADDR);
  assign rd_hit = sfr_rd && (sfr_addr == EOC_CTRL_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ext_osc_mode_field_nxt = ext_osc_mode_field_r;
    bias_nxt = bias_r;
    settle_nxt = (settle_r != 2'h0) ? settle_r - 2'h1 : 2'h0;
    if (wr_hit) begin
      ext_osc_mode_field_nxt = sfr_wdata[EOC_MODE_MSB:EOC_MODE_LSB];
      bias_nxt = sfr_wdata[EOC_BIAS_MSB:EOC_BIAS_LSB];
      // bit 3 is not stored; software keeps it zero
      if (sfr_wdata[EOC_MODE_MSB:EOC_MODE_LSB] != ext_osc_mode_field_r) begin
        settle_nxt = EOC_SETTLE_CYC;
      end
    end
    mode_new = eoc_mode_t'(ext_osc_mode_field_nxt);
    en_nxt = mode_new[2] || mode_new[1];
    cmos_nxt = (mode_new == EOC_CMOS) || (mode_new == EOC_CMOS_DIV2);
    rc_nxt = (mode_new == EOC_RC);
    cap_nxt = (mode_new == EOC_CAP);
    xtal_nxt = (mode_new == EOC_XTAL) || (mode_new == EOC_XTAL_DIV2);
    div2_nxt = (mode_new == EOC_CMOS_DIV2) || (mode_new == EOC_XTAL_DIV2);
  end

  // status only from a live, non-CMOS mode; masked while a new mode settles
  always_comb begin
    valid_nxt = osc_running && ext_osc_mode_field_r[2] && (settle_r == 2'h0)
      && !(wr_hit && (sfr_wdata[EOC_MODE_MSB:EOC_MODE_LSB] != ext_osc_mode_field_r));
    reg_view = {ext_osc_valid_flag_r, ext_osc_mode_field_r, 1'b0, bias_r};
    rdata_nxt = rd_hit ? reg_view : 8'h00_00;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_osc_mode_field_r <= EOC_CTRL_RESET[EOC_MODE_MSB:EOC_MODE_LSB];
      bias_r <= EOC_CTRL_RESET[EOC_BIAS_MSB:EOC_BIAS_LSB];
      ext_osc_valid_flag_r <= 1'b0;
      settle_r <= 2'h0;
      rdata_r <= 8'h00_00;
      en_r <= 1'b0;
      cmos_r <= 1'b0;
      rc_r <= 1'b0;
      cap_r <= 1'b0;
      xtal_r <= 1'b0;
      div2_r <= 1'b0;
    end else begin
      ext_osc_mode_field_r <= ext_osc_mode_field_nxt;
      bias_r <= bias_nxt;
      ext_osc_valid_flag_r <= valid_nxt;
      settle_r <= settle_nxt;
      rdata_r <= rdata_nxt;
      en_r <= en_nxt;
      cmos_r <= cmos_nxt;
      rc_r <= rc_nxt;
      cap_r <= cap_nxt;
      xtal_r <= xtal_nxt;
      div2_r <= div2_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign osc_enable = en_r;
  assign cmos_sel = cmos_r;
  assign rc_sel = rc_r;
  assign cap_sel = cap_r;
  assign xtal_sel = xtal_r;
  assign div2_sel = div2_r;
  assign ext_osc_bias_level = bias_r;

  ////////////////////////////////////////////////////////////////////////////
  flag_needs_osc_a: assert property (@(posedge core_clk) disable iff (srst)
    ext_osc_valid_flag_r |-> $past(osc_running))
    else $error("valid flag set without running oscillator");
  flag_cmos_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    (cmos_r || !osc_enable) |-> !ext_osc_valid_flag_r)
    else $error("valid flag set in CMOS or off mode");
  off_mode_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_hit && sfr_wdata[6:5] == 2'b00) |=> !osc_enable && !xtal_r && !rc_r && !cap_r)
    else $error("oscillator not disabled for mode 00x");
  cmos_path_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_hit && sfr_wdata[6:4] == 3'b011) |=> cmos_sel && div2_sel && osc_enable)
    else $error("CMOS halved mode not decoded");
  rc_cap_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_hit && sfr_wdata[6:5] == 2'b10) |=> (rc_sel != cap_sel)
    && (cap_sel == $past(sfr_wdata[4])))
    else $error("RC or capacitor mode not decoded");
  xtal_path_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_hit && sfr_wdata[6:5] == 2'b11) |=> xtal_sel && (div2_sel == $past(sfr_wdata[4])))
    else $error("crystal mode not decoded");
  rsvd_read_a: assert property (@(posedge core_clk) disable iff (srst)
    $past(rd_hit) |-> (sfr_rdata[3] == 1'b0) && (sfr_rdata[2:0] == $past(bias_r)))
    else $error("reserved bit or bias readback wrong");
  bias_store_a: assert property (@(posedge core_clk) disable iff (srst)
    wr_hit |=> ext_osc_bias_level == $past(sfr_wdata[2:0]))
    else $error("bias field not stored");
  settle_mask_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_hit && sfr_wdata[6:4] != ext_osc_mode_field_r) |=> !ext_osc_valid_flag_r ##1
    !ext_osc_valid_flag_r)
    else $error("valid flag not masked after mode change");
  reset_clear_a: assert property (@(posedge core_clk)
    srst |=> !osc_enable && ext_osc_bias_level == 3'h0 && !ext_osc_valid_flag_r)
    else $error("reset did not clear register");

endmodule // eoc_ctrl
`default_nettype wire

// >>> testbench/eoc_ctrl_tb.sv
// self-checking bench for the external oscillator control register
`default_nettype none
module eoc_ctrl_tb import eoc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic osc_running = 1'b0;
  logic [7:0] sfr_addr = 8'h00_00;
  logic [7:0] sfr_wdata = 8'h00_00;
  logic [7:0] sfr_rdata;
  logic osc_enable, cmos_sel, rc_sel, cap_sel, xtal_sel, div2_sel;
  logic [2:0] ext_osc_bias_level;
  logic rd_d = 1'b0;
  logic [2:0] m, b;
  logic run;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int n_tests = 0;
  int seed_v;
  eoc_ctrl i_eoc_ctrl (.core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .osc_running(osc_running),
    .osc_enable(osc_enable), .cmos_sel(cmos_sel), .rc_sel(rc_sel), .cap_sel(cap_sel),
    .xtal_sel(xtal_sel), .div2_sel(div2_sel), .ext_osc_bias_level(ext_osc_bias_level));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    sfr_rd <= 1'b0;
  endtask
  function automatic logic [7:0] exp_out(input logic [2:0] md);
    return {2'b00, md[2:1] != 2'b00, md[2:1] == 2'b01, md == 3'h4, md == 3'h5,
      md[2:1] == 2'b11, md[1] & md[0]};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // read data stands one cycle only, so look at it mid-cycle
  always @(posedge core_clk) rd_d <= sfr_rd;
  always @(negedge core_clk) begin
    if (rd_d && exp_q.size() > 0) chk(sfr_rdata, exp_q.pop_front());
  end
  initial begin
    seed_v = $urandom(32'h4dfc);
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk) chk({2'b00, osc_enable, cmos_sel, rc_sel, cap_sel, xtal_sel,
      div2_sel}, exp_out(3'h0));
    rd(EOC_CTRL_ADDR, EOC_CTRL_RESET);
    for (int i = 0; i < 16; i++) begin
      m = i[2:0];
      b = 3'($urandom);
      run = 1'($urandom);
      osc_running <= run;
      wr(EOC_CTRL_ADDR, {1'b0, m, 1'b0, b});
      repeat (3) @(posedge core_clk);
      @(negedge core_clk) chk({2'b00, osc_enable, cmos_sel, rc_sel, cap_sel, xtal_sel,
        div2_sel}, exp_out(m));
      chk({5'h00, ext_osc_bias_level}, {5'h00, b});
      rd(EOC_CTRL_ADDR, {m[2] & run, m, 1'b0, b});
    end
    // mode change masks the flag: a read right after the write sees 0, the next sees 1
    m = 3'h4;
    b = 3'h5;
    run = 1'b1;
    osc_running <= 1'b1;
    wr(EOC_CTRL_ADDR, 8'h00_45);
    rd(EOC_CTRL_ADDR, 8'h00_45);
    rd(EOC_CTRL_ADDR, 8'h00_C5);
    // other addresses must neither answer nor disturb the register
    wr(8'h00_B0, 8'h00_47);
    rd(8'h00_B0, 8'h00_00);
    rd(EOC_CTRL_ADDR, {m[2] & run, m, 1'b0, b});
    // second reset in mid-run must clear everything again
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk) chk({osc_enable, cmos_sel, rc_sel, cap_sel, xtal_sel, div2_sel,
      ext_osc_bias_level[1:0]}, 8'h00_00);
    chk({5'h00, ext_osc_bias_level}, 8'h00_00);
    rd(EOC_CTRL_ADDR, EOC_CTRL_RESET);
    for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge core_clk);
    if (exp_q.size() > 0) mismatches++;
    conclude();
  end
endmodule // eoc_ctrl_tb
`default_nettype wire
